/* rtl/rtcaf_flags.sv */
// Alarm compare, countdown timer and periodic tick flags of the clock
// Notes on behaviour
// - Compare each enabled alarm field to time
// - Minute alarm: bit7 off, BCD minutes
// - Hour alarm: bit7 off, 12/24h layout
// - Date alarm: bit7 off, BCD date
// - Weekday alarm: bit7 off, weekday 0-6
// - Alarm flag sets on first match, sticky
// - Re-set only on next matching time advance
// - Disabled alarm fields are ignored
// - Flag register write ANDs flags
// - Tick flag bit5, alarm bit3, countdown bit2
// - Setup bit7 enables countdown timer
// - Bits 1:0 select countdown source clock
// - Load value n sets period n/f
// - Tick interrupt per second or minute
// - Tick flag set per selected counter increment
// - Tick pulse regardless of flag state
// - Minute-only tick flag clears after one second
// - Hour format follows hour-format select input
// - At count 1 set flag and reload
// - Load value zero stops the timer
`timescale 1ns/100ps
`include "rtcaf_map.svh"
module rtcaf_flags
   import rtcaf_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata,
   input  wire logic             tick_4096hz,
   input  wire logic             tick_64hz,
   input  wire logic             sec_inc,
   input  wire logic             min_inc,
   input  wire logic             time_upd,
   input  wire logic [6:0]       cur_mm,
   input  wire logic [5:0]       cur_hh,
   input  wire logic [5:0]       cur_date,
   input  wire logic [2:0]       cur_dow,
   input  wire logic             hour_12_mode,
   input  wire logic             sec_tick_irq_en,
   input  wire logic             slow_tick_irq_en,
   output logic                  alarm_flag,
   output logic                  periodic_tick_flag,
   output logic                  countdown_flag,
   output logic                  periodic_tick_pulse,
   output logic                  countdown_pulse,
   output logic [CNT_W-1:0]      countdown_value
);

   logic [7:0]       alarm_mm_reg;
   logic [7:0]       alarm_hh_reg;
   logic [7:0]       alarm_date_reg;
   logic [7:0]       alarm_dow_reg;
   logic [7:0]       countdown_setup_reg;
   logic [CNT_W-1:0] countdown_load_reg;
   logic [CNT_W-1:0] count_reg;
   logic [5:0]       min_div_reg;
   logic             match_d_reg;
   logic             auto_clr_pend_reg;
   logic             flag_wr;
   logic             match_mm;
   logic             match_hh;
   logic             match_date;
   logic             match_dow;
   logic             match_all;
   logic             alarm_set;
   logic             tick_set;
   logic             cd_src_tick;
   logic             cd_set;
   logic             countdown_run;
   rtcaf_src_e       countdown_clk_sel;
   logic             wr_en;
   logic             wr_mm;
   logic             wr_hh;
   logic             wr_date;
   logic             wr_dow;
   logic             wr_setup;
   logic             wr_load;
   logic             alarm_clr;
   logic             tick_clr;
   logic             cd_clr;
   logic [7:0]       flag_byte;
   logic [7:0]       rdata_next;

   assign flag_wr = reg_wr && (reg_addr == `RTCAF_OFS_FLAGS);
   assign countdown_run = countdown_setup_reg[`RTCAF_BIT_CD_RUN];
   assign countdown_clk_sel = rtcaf_src_e'(countdown_setup_reg[1:0]);

   // One decoded strobe per register; clk_en gates every write
   assign wr_en    = clk_en && reg_wr;
   assign wr_mm    = wr_en && (reg_addr == `RTCAF_OFS_ALARM_MM);
   assign wr_hh    = wr_en && (reg_addr == `RTCAF_OFS_ALARM_HH);
   assign wr_date  = wr_en && (reg_addr == `RTCAF_OFS_ALARM_DATE);
   assign wr_dow   = wr_en && (reg_addr == `RTCAF_OFS_ALARM_DOW);
   assign wr_setup = wr_en && (reg_addr == `RTCAF_OFS_CD_SETUP);
   assign wr_load  = wr_en && (reg_addr == `RTCAF_OFS_CD_LOAD);

   // A zero written to a flag bit clears it, a one leaves it alone
   assign alarm_clr = flag_wr && !reg_wdata[`RTCAF_BIT_ALARM_FLAG];
   assign tick_clr  = flag_wr && !reg_wdata[`RTCAF_BIT_TICK_FLAG];
   assign cd_clr    = flag_wr && !reg_wdata[`RTCAF_BIT_CD_FLAG];

   // Minute alarm keeps all eight bits: compare-off and BCD minutes
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         alarm_mm_reg <= `RTCAF_RST_ALARM;
      end else if (wr_mm) begin
         alarm_mm_reg <= reg_wdata;
      end
   end

   // Hour alarm stores unused bit 6 as zero; bit 5 is PM or a tens digit
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         alarm_hh_reg <= `RTCAF_RST_ALARM;
      end else if (wr_hh) begin
         alarm_hh_reg <= reg_wdata & 8'hBF;
      end
   end

   // Date alarm stores unused bit 6 as zero
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         alarm_date_reg <= `RTCAF_RST_ALARM;
      end else if (wr_date) begin
         alarm_date_reg <= reg_wdata & 8'hBF;
      end
   end

   // Weekday alarm keeps compare-off and the three weekday bits
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         alarm_dow_reg <= `RTCAF_RST_ALARM;
      end else if (wr_dow) begin
         alarm_dow_reg <= reg_wdata & 8'h87;
      end
   end

   // Countdown setup keeps the run bit and the source select only
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         countdown_setup_reg <= `RTCAF_RST_CD_SETUP;
      end else if (wr_setup) begin
         countdown_setup_reg <= reg_wdata & 8'h83;
      end
   end

   // Reload value n; zero parks the timer
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         countdown_load_reg <= '0;
      end else if (wr_load) begin
         countdown_load_reg <= reg_wdata[CNT_W-1:0];
      end
   end

   // Field compares; a disabled field counts as matching
   always_comb begin
      match_mm   = alarm_mm_reg[`RTCAF_BIT_COMPARE_OFF] ||
                   (alarm_mm_reg[6:0] == cur_mm);
      if (hour_12_mode) begin
         match_hh = alarm_hh_reg[4:0] == cur_hh[4:0] &&
                    alarm_hh_reg[`RTCAF_BIT_PM] == cur_hh[5];
      end else begin
         match_hh = alarm_hh_reg[5:0] == cur_hh;
      end
      match_hh   = match_hh || alarm_hh_reg[`RTCAF_BIT_COMPARE_OFF];
      match_date = alarm_date_reg[`RTCAF_BIT_COMPARE_OFF] ||
                   (alarm_date_reg[5:0] == cur_date);
      match_dow  = alarm_dow_reg[`RTCAF_BIT_COMPARE_OFF] ||
                   (alarm_dow_reg[2:0] == cur_dow);
      match_all  = match_mm && match_hh && match_date && match_dow;
   end

   // Rising edge on a time update only, so a cleared flag waits
   // for the time to advance into the alarm again
   assign alarm_set = time_upd && match_all && !match_d_reg;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         match_d_reg <= 1'b1;
      end else if (clk_en && time_upd) begin
         match_d_reg <= match_all;
      end
   end

   // Second tick wins over minute tick; none when both off
   assign tick_set = sec_tick_irq_en ? sec_inc :
                     (slow_tick_irq_en && min_inc);

   // Minute divider feeds the one-sixtieth hertz source
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         min_div_reg <= '0;
      end else if (clk_en && sec_inc) begin
         min_div_reg <= (min_div_reg == `RTCAF_MIN_TICKS - 6'h01) ?
                        6'h00 : min_div_reg + 6'h01;
      end
   end

   always_comb begin
      case (countdown_clk_sel)
         RTCAF_SRC_4096HZ: cd_src_tick = tick_4096hz;
         RTCAF_SRC_64HZ:   cd_src_tick = tick_64hz;
         RTCAF_SRC_1HZ:    cd_src_tick = sec_inc;
         RTCAF_SRC_60TH:   cd_src_tick = sec_inc &&
            (min_div_reg == `RTCAF_MIN_TICKS - 6'h01);
         default:          cd_src_tick = 1'b0;
      endcase
   end

   // Countdown: n source ticks per period, zero holds it stopped
   assign cd_set = countdown_run && cd_src_tick &&
                   (countdown_load_reg != '0) &&
                   (count_reg <= CNT_W'(1));

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         count_reg <= '0;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == `RTCAF_OFS_CD_LOAD) begin
            count_reg <= reg_wdata[CNT_W-1:0]; // Immediate effect
         end else if (countdown_load_reg == '0) begin
            count_reg <= '0;
         end else if (countdown_run && cd_src_tick) begin
            if (count_reg <= CNT_W'(1)) begin
               count_reg <= countdown_load_reg;
            end else begin
               count_reg <= count_reg - CNT_W'(1);
            end
         end
      end
   end

   // Alarm flag is sticky; a new match wins over a clear in one cycle
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         alarm_flag <= 1'b0;
      end else if (clk_en) begin
         if (alarm_set) begin
            alarm_flag <= 1'b1;
         end else if (alarm_clr) begin
            alarm_flag <= 1'b0;
         end
      end
   end

   // Countdown flag: a period end wins over a clear, so none is lost
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         countdown_flag <= 1'b0;
      end else if (clk_en) begin
         if (cd_set) begin
            countdown_flag <= 1'b1;
         end else if (cd_clr) begin
            countdown_flag <= 1'b0;
         end
      end
   end

   // Tick flag; in minute-only mode it drops one second after it
   // was set, and a software clear does the same at once
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         periodic_tick_flag <= 1'b0;
      end else if (clk_en) begin
         if (tick_set) begin
            periodic_tick_flag <= 1'b1;
         end else if ((auto_clr_pend_reg && sec_inc) || tick_clr) begin
            periodic_tick_flag <= 1'b0;
         end
      end
   end

   // Pending auto clear, armed only when the minute tick set the flag
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         auto_clr_pend_reg <= 1'b0;
      end else if (clk_en) begin
         if (tick_set) begin
            auto_clr_pend_reg <= !sec_tick_irq_en;
         end else if (sec_inc || tick_clr) begin
            auto_clr_pend_reg <= 1'b0;
         end
      end
   end

   // Tick pulse follows every tick event, whatever the flag holds
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         periodic_tick_pulse <= 1'b0;
      end else if (clk_en) begin
         periodic_tick_pulse <= tick_set;
      end
   end

   // Countdown pulse marks each period end
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         countdown_pulse <= 1'b0;
      end else if (clk_en) begin
         countdown_pulse <= cd_set;
      end
   end

   // Flag byte as the host sees it; unused positions read zero
   always_comb begin
      flag_byte = `RTCAF_RST_ZERO;
      flag_byte[`RTCAF_BIT_TICK_FLAG]  = periodic_tick_flag;
      flag_byte[`RTCAF_BIT_ALARM_FLAG] = alarm_flag;
      flag_byte[`RTCAF_BIT_CD_FLAG]    = countdown_flag;
   end

   // Read select; the timer byte is the live count, not n
   always_comb begin
      case (reg_addr)
         `RTCAF_OFS_FLAGS:      rdata_next = flag_byte;
         `RTCAF_OFS_ALARM_MM:   rdata_next = alarm_mm_reg;
         `RTCAF_OFS_ALARM_HH:   rdata_next = alarm_hh_reg;
         `RTCAF_OFS_ALARM_DATE: rdata_next = alarm_date_reg;
         `RTCAF_OFS_ALARM_DOW:  rdata_next = alarm_dow_reg;
         `RTCAF_OFS_CD_SETUP:   rdata_next = countdown_setup_reg;
         `RTCAF_OFS_CD_LOAD:    rdata_next = 8'(count_reg);
         default:               rdata_next = `RTCAF_RST_ZERO;
      endcase
   end

   // Read data is registered and holds until the next read
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         reg_rdata <= `RTCAF_RST_ZERO;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   assign countdown_value = count_reg;

endmodule : rtcaf_flags

/* rtl/rtcaf_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef RTCAF_MAP_SVH
`define RTCAF_MAP_SVH
`define RTCAF_OFS_FLAGS      8'h01
`define RTCAF_OFS_ALARM_MM   8'h09
`define RTCAF_OFS_ALARM_HH   8'h0A
`define RTCAF_OFS_ALARM_DATE 8'h0B
`define RTCAF_OFS_ALARM_DOW  8'h0C
`define RTCAF_OFS_CD_SETUP   8'h0E
`define RTCAF_OFS_CD_LOAD    8'h0F
`define RTCAF_BIT_COMPARE_OFF 7
`define RTCAF_BIT_TICK_FLAG   5
`define RTCAF_BIT_ALARM_FLAG  3
`define RTCAF_BIT_CD_FLAG     2
`define RTCAF_BIT_CD_RUN      7
`define RTCAF_BIT_PM          5
`define RTCAF_RST_ALARM      8'h80
`define RTCAF_RST_CD_SETUP   8'h03
`define RTCAF_RST_ZERO       8'h00
`define RTCAF_MIN_TICKS      6'h3C
`endif

/* rtl/rtcaf_pkg.sv */
// Types shared by the alarm and timer flag block
package rtcaf_pkg;
   typedef enum logic [1:0] {
      RTCAF_SRC_4096HZ,
      RTCAF_SRC_64HZ,
      RTCAF_SRC_1HZ,
      RTCAF_SRC_60TH
   } rtcaf_src_e;
endpackage : rtcaf_pkg

/* verif/rtcaf_chk_sva.sv */
// Checker of flag, pulse and countdown behaviour at the block ports
`timescale 1ns/100ps
`include "rtcaf_map.svh"
module rtcaf_chk #(
   parameter int CNT_W = 8
) (
   input wire logic             mclk,
   input wire logic             reset_n,
   input wire logic             clk_en,
   input wire logic             reg_wr,
   input wire logic [7:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic             sec_inc,
   input wire logic             min_inc,
   input wire logic             time_upd,
   input wire logic             sec_tick_irq_en,
   input wire logic             slow_tick_irq_en,
   input wire logic             alarm_flag,
   input wire logic             periodic_tick_flag,
   input wire logic             countdown_flag,
   input wire logic             periodic_tick_pulse,
   input wire logic             countdown_pulse,
   input wire logic [CNT_W-1:0] countdown_value
);
   // Host write to the flag byte, used by the clear and keep checks
   logic flag_wr;
   assign flag_wr = clk_en && reg_wr && reg_addr == `RTCAF_OFS_FLAGS;
   // All checks run on the system clock and sleep through reset
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   tick_sec_a: assert property (clk_en && sec_inc && sec_tick_irq_en
      |-> ##[1:2] periodic_tick_pulse) else $error("tick pulse missing");
   tick_none_a: assert property ($rose(periodic_tick_flag)
      |-> $past(sec_tick_irq_en) || $past(slow_tick_irq_en))
      else $error("tick flag set with ticks off");
   auto_clear_a: assert property (clk_en && sec_inc && slow_tick_irq_en
      && !sec_tick_irq_en && !min_inc |-> ##[1:2] !periodic_tick_flag)
      else $error("minute tick flag not auto cleared");
   cd_pulse_a: assert property (countdown_pulse |-> countdown_flag)
      else $error("countdown pulse without flag");
   alarm_clear_a: assert property (flag_wr && !reg_wdata[3]
      && !time_upd |=> !alarm_flag) else $error("alarm flag not cleared");
   alarm_sticky_a: assert property (alarm_flag
      && !(flag_wr && !reg_wdata[3]) |=> alarm_flag)
      else $error("alarm flag dropped");
   cd_sticky_a: assert property (countdown_flag
      && !(flag_wr && !reg_wdata[2]) |=> countdown_flag)
      else $error("countdown flag dropped");
   alarm_cause_a: assert property ($rose(alarm_flag)
      |-> $past(time_upd) || $past(time_upd, 2))
      else $error("alarm flag set without time update");
   cd_load_a: assert property (clk_en && reg_wr
      && reg_addr == `RTCAF_OFS_CD_LOAD |=> countdown_value == $past(reg_wdata))
      else $error("count not loaded");
endmodule : rtcaf_chk

/* verif/rtcaf_host.sv */
// Host model: register master making single byte accesses
`timescale 1ns/100ps
module rtcaf_host (
   input  wire logic       mclk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   // Strobes idle low; data is inverted on release so stale bytes never pass
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      d = reg_rdata;
   endtask : rd
   // Read-modify-write so that flags other than the masked ones survive
   task clr(input logic [7:0] m);
      logic [7:0] v;
      rd(8'h01, v);
      wr(8'h01, v & ~m);
   endtask : clr
endmodule : rtcaf_host

/* verif/test_rtc_alarm_and_timer_flags.sv */
// Self-checking bench for the alarm and timer flag block
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %h exp %h", $time, g, e); end end
module test_rtc_alarm_and_timer_flags;
   logic mclk = 1'b0, reset_n = 1'b0, time_upd = 1'b0, hour_12_mode = 1'b0;
   logic sec_tick_irq_en = 1'b0, slow_tick_irq_en = 1'b0;
   logic tick_4096hz = 1'b0, tick_64hz = 1'b0, sec_inc = 1'b0, min_inc = 1'b0;
   logic [6:0] cur_mm = 7'h00;
   logic [5:0] cur_hh = 6'h15, cur_date = 6'h01;
   logic [2:0] cur_dow = 3'h2;
   logic reg_wr, reg_rd, alarm_flag, periodic_tick_flag, countdown_flag;
   logic periodic_tick_pulse, countdown_pulse;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, countdown_value, v;
   int n_errors = 0, tests_run = 0, s, n_tp = 0, n_cp = 0;
   logic clk_en = 1'b1;
   logic [7:0] ad [8] = '{8'h01, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h05};
   logic [7:0] rv [8] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03, 8'h00, 8'h00};
   logic [7:0] wv [8] = '{8'h00, 8'hFF, 8'hBF, 8'hBF, 8'h87, 8'h83, 8'hFF, 8'h00};
   // System clock, 25 ns period
   always #12.5 mclk = ~mclk;
   rtcaf_flags #(.CNT_W(8)) DUT (.*);
   rtcaf_host h (.*);
   // Pulse tallies, taken mid-cycle where each one-cycle pulse stands
   always @(negedge mclk) begin
      if (periodic_tick_pulse === 1'b1) n_tp++;
      if (countdown_pulse === 1'b1) n_cp++;
   end
   // One-cycle pulses: 0 fast tick, 1 slow tick, 2 second, 3 minute
   task tk(input int k, input int n);
      repeat (n) begin
         @(posedge mclk);
         {min_inc, sec_inc, tick_64hz, tick_4096hz} <= 4'h1 << k;
         @(posedge mclk);
         {min_inc, sec_inc, tick_64hz, tick_4096hz} <= 4'h0;
      end
      repeat (2) @(negedge mclk);
   endtask : tk
   task tu(input logic [6:0] m);
      @(posedge mclk);
      cur_mm <= m;
      time_upd <= 1'b1;
      @(posedge mclk);
      time_upd <= 1'b0;
      repeat (3) @(negedge mclk);
   endtask : tu
   task finish_test;
      $display("Checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   // Main sequence: registers, alarm, countdown, periodic tick
   initial begin
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         h.rd(ad[i], v);
         `CHK(v, rv[i])
         h.wr(ad[i], 8'hFF);
         h.rd(ad[i], v);
         `CHK(v, wv[i])
      end
      h.wr(8'h09, 8'h30);
      tu(7'h29);
      tu(7'h30);
      `CHK(alarm_flag, 1'b1)
      h.wr(8'h01, 8'hFF);
      `CHK(alarm_flag, 1'b1)
      h.clr(8'h08);
      tu(7'h30);
      `CHK(alarm_flag, 1'b0)
      tu(7'h31);
      tu(7'h30);
      `CHK(alarm_flag, 1'b1)
      h.clr(8'h08);
      h.wr(8'h0C, 8'h03);
      tu(7'h31);
      tu(7'h30);
      `CHK(alarm_flag, 1'b0)
      @(posedge mclk);
      cur_dow <= 3'h3;
      tu(7'h30);
      `CHK(alarm_flag, 1'b1)
      // Twelve-hour compare: AM seven must miss a PM seven, PM must hit
      h.clr(8'h08);
      @(posedge mclk);
      hour_12_mode <= 1'b1;
      cur_hh <= 6'h27;
      h.wr(8'h0A, 8'h07);
      tu(7'h31);
      tu(7'h30);
      `CHK(alarm_flag, 1'b0)
      h.wr(8'h0A, 8'h27);
      tu(7'h31);
      tu(7'h30);
      `CHK(alarm_flag, 1'b1)
      // Countdown with n of 2 on each source; the slowest has a loose phase
      for (s = 0; s < 4; s++) begin
         h.wr(8'h0F, 8'h02);
         h.wr(8'h0E, {6'h20, s[1:0]});
         tk(s == 0 ? 1 : 0, 1);
         `CHK(countdown_value, 8'h02)
         tk(s == 3 ? 2 : s, s == 3 ? 119 : 1);
         if (s < 3) `CHK(countdown_flag, 1'b0)
         tk(s == 3 ? 2 : s, 1);
         `CHK(countdown_flag, 1'b1)
         if (s < 3) `CHK(countdown_value, 8'h02)
         h.clr(8'h04);
      end
      h.wr(8'h0F, 8'h00);
      h.wr(8'h0E, 8'h80);
      tk(0, 3);
      `CHK(countdown_flag, 1'b0)
      `CHK(countdown_value, 8'h00)
      `CHK(n_cp, 4)
      h.wr(8'h0E, 8'h00);
      h.wr(8'h0F, 8'h01);
      tk(0, 3);
      `CHK(countdown_value, 8'h01)
      // Clock enable low: a load write must not take effect
      @(posedge mclk);
      clk_en <= 1'b0;
      h.wr(8'h0F, 8'h05);
      tk(0, 2);
      @(posedge mclk);
      clk_en <= 1'b1;
      `CHK(countdown_value, 8'h01)
      @(posedge mclk);
      sec_tick_irq_en <= 1'b1;
      tk(2, 2);
      `CHK(periodic_tick_flag, 1'b1)
      `CHK(n_tp, 2)
      @(posedge mclk);
      sec_tick_irq_en <= 1'b0;
      slow_tick_irq_en <= 1'b1;
      h.clr(8'h20);
      tk(3, 1);
      `CHK(periodic_tick_flag, 1'b1)
      tk(2, 1);
      `CHK(periodic_tick_flag, 1'b0)
      @(posedge mclk);
      slow_tick_irq_en <= 1'b0;
      tk(3, 1);
      tk(2, 1);
      `CHK(periodic_tick_flag, 1'b0)
      `CHK(n_tp, 3)
      finish_test();
   end
   // Watchdog: the run needs a few hundred cycles, allow 40000
   initial begin
      #1_000_000;
      n_errors++;
      finish_test();
   end
endmodule : test_rtc_alarm_and_timer_flags
bind rtcaf_flags rtcaf_chk #(.CNT_W(CNT_W)) u_chk (.*);
